// >>> src/pca_defs.vh
// Constants for the counter array timebase block.
`ifndef PCA_DEFS_VH
`define PCA_DEFS_VH
`define PCA_SEL_DIV12   3'h0
`define PCA_SEL_DIV4    3'h1
`define PCA_SEL_T0OVF   3'h2
`define PCA_SEL_EXTIN   3'h3
`define PCA_SEL_SYSCLK  3'h4
`define PCA_SEL_OSCDIV8 3'h5
`define PCA_DIV12_LAST  4'hB
`define PCA_DIV4_LAST   4'h3
`define PCA_CNT_RESET   16'h0000
`define PCA_CNT_MAX     16'hFFFF
`endif

// >>> src/pca_timebase.v
// Sixteen-bit counter with selectable timebase, coherent reads and overflow flag.
//
// Contract
// RULE1 - Sixteen-bit up-counter read as two bytes.
// RULE2 - Low byte read snapshots high byte.
// RULE3 - Software reads low byte before high.
// RULE4 - Reads never disturb counting.
// RULE5 - Three-bit select picks count source.
// RULE6 - External input counts falling edges only.
// RULE7 - Oscillator tick synchronised before counting.
// RULE8 - Rollover to zero sets overflow flag.
// RULE9 - Enabled flag raises interrupt request.
// RULE10 - Only software clears overflow flag.
// RULE11 - Idle control low keeps counting.
// RULE12 - Reset enters watchdog mode, restricts writes.
// RULE13 - Idle control high halts during idle.
`timescale 1ns/10ps
`include "pca_defs.vh"

module pca_timebase (
    CLK,
    RST_N,
    CE,
    TIMEBASE_SELECT,
    OVERFLOW_IRQ_ENABLE,
    IDLE_HALT_CONTROL,
    CPU_IDLE,
    TIMER0_OVERFLOW,
    EXTERNAL_COUNT_INPUT,
    OSC_DIV8_TICK,
    READ_LOW,
    READ_HIGH,
    WRITE_LOW,
    WRITE_HIGH,
    WRITE_DATA,
    CLEAR_FLAG,
    WATCHDOG_DISABLE,
    READ_DATA,
    COUNTER_OVERFLOW_FLAG,
    IRQ,
    MODULE_WATCHDOG_MODE
);
    input  wire       CLK;
    input  wire       RST_N;
    input  wire       CE;
    input  wire [2:0] TIMEBASE_SELECT;
    input  wire       OVERFLOW_IRQ_ENABLE;
    input  wire       IDLE_HALT_CONTROL;
    input  wire       CPU_IDLE;
    input  wire       TIMER0_OVERFLOW;
    input  wire       EXTERNAL_COUNT_INPUT;
    input  wire       OSC_DIV8_TICK;
    input  wire       READ_LOW;
    input  wire       READ_HIGH;
    input  wire       WRITE_LOW;
    input  wire       WRITE_HIGH;
    input  wire [7:0] WRITE_DATA;
    input  wire       CLEAR_FLAG;
    input  wire       WATCHDOG_DISABLE;
    output reg  [7:0] READ_DATA;
    output reg        COUNTER_OVERFLOW_FLAG;
    output wire       IRQ;
    output reg        MODULE_WATCHDOG_MODE;

    reg  [15:0] count;
    reg  [7:0]  snapshot;
    reg  [3:0]  prescale;
    reg         ext_prev;
    reg  [2:0]  osc_pipe;
    reg         tick;
    wire        run;
    wire [3:0]  pre_last;
    wire        pre_done;
    wire        ext_fall;
    wire        osc_rise;
    wire [2:0]  osc_src;
    wire        write_any;
    wire        write_low_ok;
    wire        write_high_ok;
    wire        advance;
    wire        rollover;
    genvar      g;

    //////////////////////////////////////////////////////////////////////////////
    // Select decoding.

    // Terminal count of the prescaler for one select code.
    function [3:0] last_of;
        input [2:0] sel;
        begin
            if (sel == `PCA_SEL_DIV4) begin
                last_of = `PCA_DIV4_LAST;
            end else begin
                last_of = `PCA_DIV12_LAST;
            end
        end
    endfunction

    // True for the two select codes whose ticks come from the prescaler.
    function uses_prescaler;
        input [2:0] sel;
        begin
            uses_prescaler = (sel == `PCA_SEL_DIV12) || (sel == `PCA_SEL_DIV4);
        end
    endfunction

    //////////////////////////////////////////////////////////////////////////////
    // Timebase selection.

    // Counting stops only when idle halting is requested and the CPU idles.
    assign run = ~(IDLE_HALT_CONTROL & CPU_IDLE); // [RULE11] [RULE13]

    // The prescaler wraps at the terminal count of the chosen divider.
    assign pre_last = last_of(TIMEBASE_SELECT);
    assign pre_done = uses_prescaler(TIMEBASE_SELECT) && (prescale == pre_last);

    // Only a high-to-low step on the count input and a rising oscillator step give ticks.
    assign ext_fall = ext_prev & ~EXTERNAL_COUNT_INPUT; // [RULE6]
    assign osc_rise = osc_pipe[1] & ~osc_pipe[2]; // [RULE7]

    // Choose one count tick per cycle from the selected source.
    always @* begin
        case (TIMEBASE_SELECT) // [RULE5]
            `PCA_SEL_DIV12:   tick = pre_done;
            `PCA_SEL_DIV4:    tick = pre_done;
            `PCA_SEL_T0OVF:   tick = TIMER0_OVERFLOW;
            `PCA_SEL_EXTIN:   tick = ext_fall;
            `PCA_SEL_SYSCLK:  tick = 1'b1;
            `PCA_SEL_OSCDIV8: tick = osc_rise;
            default:          tick = 1'b0;
        endcase
    end

    // The prescaler runs only with counting and restarts from zero on another source.
    // A value above the terminal count after a select change wraps at once.
    always @(posedge CLK) begin
        if (!RST_N) begin
            prescale <= 4'h0;
        end else if (CE && run) begin
            if (!uses_prescaler(TIMEBASE_SELECT) || pre_done || prescale > pre_last) begin
                prescale <= 4'h0;
            end else begin
                prescale <= prescale + 4'h1;
            end
        end
    end

    // Edge history of the count input resets to its idle high level, so no false edge.
    always @(posedge CLK) begin
        if (!RST_N) begin
            ext_prev <= 1'b1;
        end else if (CE) begin
            ext_prev <= EXTERNAL_COUNT_INPUT;
        end
    end

    // Two synchroniser stages and one history stage for the oscillator tick.
    // Only the second stage reads the first, which keeps metastability contained.
    assign osc_src = {osc_pipe[1:0], OSC_DIV8_TICK};
    generate
        for (g = 0; g < 3; g = g + 1) begin : osc_stage
            always @(posedge CLK) begin
                if (!RST_N) begin
                    osc_pipe[g] <= 1'b0;
                end else if (CE) begin
                    osc_pipe[g] <= osc_src[g]; // [RULE7]
                end
            end
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////////
    // Counter, snapshot, flag and watchdog mode.

    // Writes are refused while watchdog mode holds; an accepted write wins over a tick.
    // Reads take no part in these terms, so they never disturb counting.
    assign write_any     = (WRITE_LOW | WRITE_HIGH) & ~MODULE_WATCHDOG_MODE; // [RULE12]
    assign write_low_ok  = WRITE_LOW & ~MODULE_WATCHDOG_MODE;
    assign write_high_ok = WRITE_HIGH & ~WRITE_LOW & ~MODULE_WATCHDOG_MODE;
    assign advance       = run & tick & ~write_any; // [RULE4]
    assign rollover      = advance & (count == `PCA_CNT_MAX);

    // The sixteen-bit counter takes a byte write or advances by one.
    // The low byte write wins when both strobes come together.
    always @(posedge CLK) begin
        if (!RST_N) begin
            count <= `PCA_CNT_RESET;
        end else if (CE) begin
            if (write_low_ok) begin
                count[7:0] <= WRITE_DATA;
            end else if (write_high_ok) begin
                count[15:8] <= WRITE_DATA;
            end else if (advance) begin
                count <= count + 16'h0001; // [RULE1]
            end
        end
    end

    // Watchdog mode is entered on every reset and left only on request.
    // Leaving takes effect on the next cycle, so a write in the same cycle is refused.
    always @(posedge CLK) begin
        if (!RST_N) begin
            MODULE_WATCHDOG_MODE <= 1'b1; // [RULE12]
        end else if (CE) begin
            if (WATCHDOG_DISABLE) begin
                MODULE_WATCHDOG_MODE <= 1'b0;
            end
        end
    end

    // The overflow flag is sticky; a rollover wins over a clear in the same cycle.
    // Nothing but the clear strobe lowers it, servicing the interrupt included.
    always @(posedge CLK) begin
        if (!RST_N) begin
            COUNTER_OVERFLOW_FLAG <= 1'b0;
        end else if (CE) begin
            if (rollover) begin
                COUNTER_OVERFLOW_FLAG <= 1'b1; // [RULE8]
            end else if (CLEAR_FLAG) begin
                COUNTER_OVERFLOW_FLAG <= 1'b0; // [RULE10]
            end
        end
    end

    // A low byte read captures the high byte; a high byte read returns that capture.
    // The read data holds its value until the next read strobe.
    always @(posedge CLK) begin
        if (!RST_N) begin
            snapshot  <= 8'h00;
            READ_DATA <= 8'h00;
        end else if (CE) begin
            if (READ_LOW) begin
                snapshot  <= count[15:8]; // [RULE2]
                READ_DATA <= count[7:0];
            end else if (READ_HIGH) begin
                READ_DATA <= snapshot; // [RULE2]
            end
        end
    end

    // Interrupt request follows the flag while enabled.
    assign IRQ = COUNTER_OVERFLOW_FLAG & OVERFLOW_IRQ_ENABLE; // [RULE9]
endmodule

// >>> sim/pca_timebase_monitor.sv
// Port-level assertions for the counter block.
`timescale 1ns/10ps
module pca_chk(input wire CLK, RST_N, CLEAR_FLAG, CPU_IDLE, IDLE_HALT_CONTROL,
    input wire OVERFLOW_IRQ_ENABLE, READ_LOW, READ_HIGH, WATCHDOG_DISABLE, IRQ,
    input wire [2:0] TIMEBASE_SELECT, input wire [7:0] READ_DATA,
    input wire COUNTER_OVERFLOW_FLAG, MODULE_WATCHDOG_MODE);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    wire f = COUNTER_OVERFLOW_FLAG;
    a_irq_from_flag: assert property (IRQ == (f && OVERFLOW_IRQ_ENABLE))
        else $error("irq does not follow flag");
    a_flag_sticky: assert property (f && !CLEAR_FLAG |=> f)
        else $error("flag dropped");
    a_flag_cleared: assert property ($fell(f) |-> $past(CLEAR_FLAG))
        else $error("flag fell without clear");
    a_wdog_reset: assert property ($rose(RST_N) |-> MODULE_WATCHDOG_MODE)
        else $error("watchdog mode off after reset");
    a_wdog_hold: assert property (MODULE_WATCHDOG_MODE && !WATCHDOG_DISABLE
        |=> MODULE_WATCHDOG_MODE) else $error("watchdog mode left");
    a_read_hold: assert property (!READ_LOW && !READ_HIGH |=> $stable(READ_DATA))
        else $error("read data moved");
    a_idle_halt: assert property (CPU_IDLE && IDLE_HALT_CONTROL && !f |=> !f)
        else $error("overflow while halted");
    a_reserved_quiet: assert property (TIMEBASE_SELECT >= 3'h6 && !f |=> !f)
        else $error("overflow from reserved source");
    cover property (IRQ);
    cover property ($fell(f));
    cover property (READ_LOW ##1 READ_HIGH);
endmodule
bind pca_timebase pca_chk u_chk(
    .CLK(CLK), .RST_N(RST_N), .CLEAR_FLAG(CLEAR_FLAG), .CPU_IDLE(CPU_IDLE),
    .IDLE_HALT_CONTROL(IDLE_HALT_CONTROL), .OVERFLOW_IRQ_ENABLE(OVERFLOW_IRQ_ENABLE),
    .READ_LOW(READ_LOW), .READ_HIGH(READ_HIGH), .WATCHDOG_DISABLE(WATCHDOG_DISABLE),
    .IRQ(IRQ), .TIMEBASE_SELECT(TIMEBASE_SELECT), .READ_DATA(READ_DATA),
    .COUNTER_OVERFLOW_FLAG(COUNTER_OVERFLOW_FLAG), .MODULE_WATCHDOG_MODE(MODULE_WATCHDOG_MODE));

// >>> sim/pca_src_model.sv
// Far-side event sources: external count input, oscillator tick, timer 0 pulse.
`timescale 1ns/10ps
module pca_src_model(input wire CLK, output reg EXT = 1'b1, OSC = 1'b0, T0 = 1'b0);
    reg [2:0] ph = 3'h0;
    // Each source is a fixed fraction of one free phase counter.
    always @(posedge CLK) begin
        ph  <= ph + 3'h1;
        EXT <= ph[1]; // One falling edge per 4 clocks, the allowed maximum.
        OSC <= ph[2]; // Square wave already divided by 8.
        T0  <= (ph == 3'h7);
    end
endmodule

// >>> sim/pca_timebase_tb_top.sv
// Self-checking bench for the counter block.
`timescale 1ns/10ps
module pca_timebase_tb_top;
    reg        clk = 0, rst_n = 0, rl = 0, rh = 0, ie = 0, idle = 1, ihc = 1, clr = 0;
    reg        wl = 0, wh = 0, wdis = 0;
    reg  [2:0] sel = 3'h4;
    reg  [7:0] b, wd = 8'h00;
    reg [15:0] v0, v1, dd;
    wire       ext, osc, t0, irq, flag, wdm;
    wire [7:0] rd;
    integer    n_fail = 0, checked = 0, s;
    integer    dv [0:7] = '{12, 4, 8, 4, 1, 8, 1, 1};
    pca_src_model src(.CLK(clk), .EXT(ext), .OSC(osc), .T0(t0));
    pca_timebase uut(.CLK(clk), .RST_N(rst_n), .CE(1'b1), .TIMEBASE_SELECT(sel),
        .OVERFLOW_IRQ_ENABLE(ie), .IDLE_HALT_CONTROL(ihc), .CPU_IDLE(idle), .TIMER0_OVERFLOW(t0),
        .EXTERNAL_COUNT_INPUT(ext), .OSC_DIV8_TICK(osc), .READ_LOW(rl), .READ_HIGH(rh),
        .WRITE_LOW(wl), .WRITE_HIGH(wh), .WRITE_DATA(wd), .CLEAR_FLAG(clr),
        .WATCHDOG_DISABLE(wdis), .READ_DATA(rd), .COUNTER_OVERFLOW_FLAG(flag), .IRQ(irq),
        .MODULE_WATCHDOG_MODE(wdm));
    initial forever #12.5 clk = ~clk;
    // Comparison, clock waits and register access.
    task chk(input string nm, input [15:0] seen, input [15:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED %0s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task tick(input integer n); repeat (n) @(posedge clk); endtask
    task rdb(input lo, output [7:0] v);
        rl <= lo;
        rh <= !lo;
        tick(1);
        rl <= 1'b0;
        rh <= 1'b0;
        tick(1);
        v = rd;
    endtask
    // Software order: low byte first, then the high byte from the snapshot.
    task rd16(output [15:0] v);
        rdb(1'b1, v[7:0]);
        rdb(1'b0, v[15:8]);
    endtask
    // One byte write strobe, then one idle cycle.
    task wrb(input lo, input [7:0] d);
        wl <= lo;
        wh <= !lo;
        wd <= d;
        tick(1);
        wl <= 1'b0;
        wh <= 1'b0;
        tick(1);
    endtask
    // Runs m cycles in state r from a halt and returns the count advance.
    task span(input [2:0] sl, input [1:0] r, input integer m, output [15:0] d);
        sel <= sl;
        rd16(v0);
        {idle, ihc} <= r;
        tick(m);
        {idle, ihc} <= 2'h3;
        tick(3);
        rd16(v1);
        d = v1 - v0;
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Main sequence.
    initial begin
        tick(8);
        rst_n <= 1'b1;
        tick(1);
        chk("wdog_mode", wdm, 1);
        rd16(v0);
        chk("reset_count", v0, 0);
        for (s = 0; s < 8; s = s + 1) begin
            span(s, 2'h1, 120, dd);
            chk("span", dd, s > 5 ? 0 : 120 / dv[s]);
        end
        span(3'h4, 2'h2, 120, dd);
        chk("idle_run", dd, 120);
        span(3'h4, 2'h3, 120, dd);
        chk("idle_halt", dd, 0);
        rd16(v0);
        rdb(1'b1, b);
        {idle, ihc} <= 2'h1;
        tick(600);
        {idle, ihc} <= 2'h3;
        tick(3);
        rdb(1'b0, b);
        chk("snapshot", b, v0[15:8]);
        rd16(v1);
        chk("advance", v1 - v0, 600);
        wrb(1'b1, 8'hA5);
        rd16(v0);
        chk("wr_refused", v0, v1);
        wdis <= 1'b1;
        tick(1);
        wdis <= 1'b0;
        tick(1);
        chk("wdog_left", wdm, 0);
        wrb(1'b1, 8'hF0);
        wrb(1'b0, 8'hFF);
        rd16(v1);
        chk("written", v1, 16'hFFF0);
        chk("no_ovf", flag, 0);
        {idle, ihc} <= 2'h1;
        for (s = 0; flag !== 1'b1 && s < 100; s = s + 1) begin
            tick(1);
        end
        chk("ovf", flag, 1);
        chk("irq_off", irq, 0);
        ie <= 1'b1;
        tick(20);
        chk("irq_on", irq, 1);
        clr <= 1'b1;
        tick(1);
        clr <= 1'b0;
        tick(2);
        chk("cleared", flag, 0);
        chk("irq_gone", irq, 0);
        end_of_test;
    end
    initial begin
        #250000;
        n_fail = n_fail + 1;
        end_of_test;
    end
endmodule
